// ==== clock_multiplier_sysclk_select_bench.sv ====
/*
 * Self-checking bench for the clock multiplier and system clock select block.
 * Assumes the block is the only device on its register port and that the bench
 * makes both oscillator pins itself, slower than half the control clock.
 */
module clock_multiplier_sysclk_select_bench;
    import cms_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int INT_HALF = 12;
    localparam int EXT_HALF = 20;
    localparam int WIN      = 480;
    localparam int LIMIT    = 40000;
    localparam int XTAL_WAIT = 10000;

    logic         clk;
    logic         reset;
    cms_sfr_req_t sfr_req;
    logic [7:0]   sfr_rdata;
    logic         int_osc_enable;
    logic         int_osc_pin;
    logic         ext_osc_pin;
    logic [2:0]   ext_osc_mode_field;
    logic         ext_osc_settled_pin;
    logic         crystal_valid_flag;
    cms_ticks_t   ticks;
    int           mismatches;
    int           tests_run;
    int           cyc;
    int           oc;
    int           cnt[3];
    logic [31:0]  lfsr;
    logic [7:0]   rv;
    logic [7:0]   ra;

    cms_clock_control u_cms_clock_control (
        .clk                 (clk),
        .reset               (reset),
        .sfr_req             (sfr_req),
        .sfr_rdata           (sfr_rdata),
        .int_osc_enable      (int_osc_enable),
        .int_osc_pin         (int_osc_pin),
        .ext_osc_pin         (ext_osc_pin),
        .ext_osc_mode_field  (ext_osc_mode_field),
        .ext_osc_settled_pin (ext_osc_settled_pin),
        .crystal_valid_flag  (crystal_valid_flag),
        .ticks               (ticks)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Both oscillators run free; the internal one only counts while enabled.
    always @(posedge clk) begin
        oc <= oc + 1;
        if (oc % INT_HALF == INT_HALF - 1) int_osc_pin <= ~int_osc_pin;
        if (oc % EXT_HALF == EXT_HALF - 1) ext_osc_pin <= ~ext_osc_pin;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            mismatches++;
            summarize();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic near(input int got, input int exp);
        tests_run++;
        if (got > exp + 2 || got + 2 < exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : near

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{addr: a, wr: 1'b1, wdata: d};
        @(posedge clk);
        sfr_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sfr_req.addr <= a;
        @(posedge clk);
        #1;
    endtask : rd

    // Counts system, multiplier and peripheral pulses over a fixed window.
    task automatic meas();
        repeat (100) @(posedge clk);
        cnt = '{0, 0, 0};
        repeat (WIN) begin
            @(posedge clk);
            #1;
            if (ticks.sysclk_tick === 1'b1) cnt[0]++;
            if (ticks.mult_tick === 1'b1) cnt[1]++;
            if (ticks.ext_periph_tick === 1'b1) cnt[2]++;
        end
    endtask : meas

    task automatic lock(input logic [1:0] sel, input logic ok);
        wr(MULT_CTRL_ADDR, 8'h00);
        wr(MULT_CTRL_ADDR, {6'h00, sel});
        wr(MULT_CTRL_ADDR, {6'h20, sel});
        rd(MULT_CTRL_ADDR);
        chk(sfr_rdata, {6'h20, sel});
        repeat (55) @(posedge clk);
        if (sel != MSEL_INT_DIV2) chk(crystal_valid_flag, 1'b1);
        wr(MULT_CTRL_ADDR, {6'h30, sel});
        repeat (45) @(posedge clk);
        rd(MULT_CTRL_ADDR);
        chk(sfr_rdata[5], 1'b0);
        for (int i = 0; i < 400 && sfr_rdata[5] !== 1'b1; i++) rd(MULT_CTRL_ADDR);
        chk(sfr_rdata[5], ok);
    endtask : lock

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        reset = 1'b1;
        sfr_req = '0;
        int_osc_enable = 1'b0;
        int_osc_pin = 1'b0;
        ext_osc_pin = 1'b0;
        ext_osc_mode_field = 3'h0;
        ext_osc_settled_pin = 1'b0;
        mismatches = 0;
        tests_run = 0;
        cyc = 0;
        oc = 0;
        lfsr = 32'hEF82;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(SYSCLK_SEL_ADDR);
        chk(sfr_rdata, SYSCLK_SEL_RESET);
        rd(MULT_CTRL_ADDR);
        chk(sfr_rdata, MULT_CTRL_RESET);
        wr(SYSCLK_SEL_ADDR, CSEL_INT);
        meas();
        near(cnt[0], 0);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            rv = lfsr[7:0];
            ra = lfsr[15:8];
            if (ra == SYSCLK_SEL_ADDR || ra == MULT_CTRL_ADDR) ra = ra ^ 8'h01;
            wr(ra, rv);
            rd(ra);
            chk(sfr_rdata, 8'h00);
            wr(SYSCLK_SEL_ADDR, rv);
            wr(MULT_CTRL_ADDR, rv & 8'h1F);
            rd(SYSCLK_SEL_ADDR);
            chk(sfr_rdata, rv & 8'h03);
            rd(MULT_CTRL_ADDR);
            chk(sfr_rdata, rv & 8'h03);
        end
        ext_osc_settled_pin <= 1'b1;
        // The last pass keeps crystal mode but drops the settle input.
        for (int m = 0; m < 9; m++) begin
            ext_osc_mode_field <= (m == 8) ? 3'h6 : m[2:0];
            if (m == 8) ext_osc_settled_pin <= 1'b0;
            repeat (m == 6 ? XTAL_WAIT : 6) @(posedge clk);
            chk(crystal_valid_flag, (m < 8 && m[2:1] == 2'b11));
        end
        ext_osc_settled_pin <= 1'b1;
        int_osc_enable <= 1'b1;
        wr(SYSCLK_SEL_ADDR, CSEL_INT);
        meas();
        near(cnt[0], WIN / (2 * INT_HALF));
        near(cnt[2], WIN / (2 * EXT_HALF));
        wr(SYSCLK_SEL_ADDR, CSEL_EXT);
        meas();
        near(cnt[0], WIN / (2 * EXT_HALF));
        for (int s = 0; s < 3; s++) begin
            lock(s[1:0], 1'b1);
            meas();
            near(cnt[1], MULT_FACTOR * WIN / (s == 1 ? 2 * EXT_HALF :
                 s == 0 ? 4 * INT_HALF : 4 * EXT_HALF));
        end
        wr(SYSCLK_SEL_ADDR, CSEL_MULT);
        meas();
        near(cnt[0], MULT_FACTOR * WIN / (4 * EXT_HALF));
        wr(SYSCLK_SEL_ADDR, CODE_RESERVED);
        meas();
        near(cnt[0], MULT_FACTOR * WIN / (4 * EXT_HALF));
        wr(MULT_CTRL_ADDR, 8'h02);
        rd(MULT_CTRL_ADDR);
        chk(sfr_rdata, 8'h02);
        meas();
        near(cnt[1], 0);
        lock(2'b11, 1'b0);
        wr(MULT_CTRL_ADDR, 8'h00);
        wr(MULT_CTRL_ADDR, 8'hC1);
        repeat (400) @(posedge clk);
        rd(MULT_CTRL_ADDR);
        chk(sfr_rdata[5], 1'b0);
        summarize();
    end
endmodule : clock_multiplier_sysclk_select_bench

// ==== cms_clock_control.sv ====
/*
 * Clock multiplier with input select, lock sequence and ready flag, plus the system
 * clock source multiplexer. Oscillators arrive as raw pin levels and are sampled on
 * clk; every derived clock leaves as a one-cycle enable pulse on clk. The external
 * oscillator mode field and its settle indication come from the oscillator control.
 */
// Operation
// - The multiplier output runs at four times the rate of its selected input.
// - Multiplier input select 00 is internal/2, 01 is external, 10 is external/2, 11 reserved.
// - Control bit 7 enables the multiplier when one and disables it when zero.
// - Initialize is zero when enabling, and a later write of one starts initialization.
// - The read-only ready flag in bit 5 is zero until the multiplier has locked.
// - The internal oscillator is usable as system clock right after it is enabled.
// - Hardware sets the crystal valid flag once the external oscillator has settled.
// - System clock select 00 is internal, 01 is external, 10 is multiplier, 11 reserved.
// - The external oscillator stays available to timers while the internal one is system clock.
// - The source may change on the fly, and software only picks an enabled, settled source.
// - Unused control bits 4..2 and select bits 7..2 read zero and ignore writes.
// - The crystal valid flag carries meaning only in the two crystal modes.
// - Mode field: 00x off, 010 CMOS, 011 CMOS/2, 100 RC, 101 C, 110 crystal, 111 crystal/2.
module cms_clock_control
    import cms_pkg::*;
#(
    parameter int unsigned PER_W = 16
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire cms_sfr_req_t  sfr_req,
    output logic [7:0]         sfr_rdata,
    input  wire logic          int_osc_enable,
    input  wire logic          int_osc_pin,
    input  wire logic          ext_osc_pin,
    input  wire logic [2:0]    ext_osc_mode_field,
    input  wire logic          ext_osc_settled_pin,
    output logic               crystal_valid_flag,
    output cms_ticks_t         ticks
);

    typedef struct packed {
        logic [2:0]       int_sync;
        logic [2:0]       ext_sync;
        logic [1:0]       xtal_sync;
        logic             int_half;
        logic             ext_half;
        logic             mult_enable;
        logic             mult_initialize;
        logic [1:0]       mult_input_select;
        logic [1:0]       sysclk_source_select;
        logic [1:0]       active_sel;
        cms_mstate_t      mstate;
        logic [15:0]      lock_cnt;
        logic [PER_W-1:0] per_cnt;
        logic [PER_W-1:0] period;
        logic             period_valid;
        logic [PER_W-1:0] phase;
        logic             crystal_valid;
        cms_ticks_t       ticks;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic             int_rise;
    logic             ext_rise;
    logic             mult_in_tick;
    logic [PER_W-1:0] quarter;
    logic             wr_ctrl;
    logic             wr_sel;
    logic             new_tick;

    function automatic logic src_tick(input logic [1:0] sel, input logic ti, input logic te,
                                      input logic tm);
        case (sel)
            CSEL_INT:  src_tick = ti;
            CSEL_EXT:  src_tick = te;
            CSEL_MULT: src_tick = tm;
            default:   src_tick = 1'b0;
        endcase
    endfunction : src_tick

    // Edges are taken from the second and third stages only.
    assign int_rise = s_q.int_sync[1] & ~s_q.int_sync[2] & int_osc_enable;
    assign ext_rise = s_q.ext_sync[1] & ~s_q.ext_sync[2];
    assign wr_ctrl  = sfr_req.wr && sfr_req.addr == MULT_CTRL_ADDR;
    assign wr_sel   = sfr_req.wr && sfr_req.addr == SYSCLK_SEL_ADDR;

    always_comb begin
        case (s_q.mult_input_select)
            MSEL_INT_DIV2: mult_in_tick = int_rise & s_q.int_half;
            MSEL_EXT:      mult_in_tick = ext_rise;
            MSEL_EXT_DIV2: mult_in_tick = ext_rise & s_q.ext_half;
            default:       mult_in_tick = 1'b0;
        endcase
    end

    assign quarter = (s_q.period >> 2) == '0 ? PER_W'(1) : (s_q.period >> 2);

    always_comb begin
        s_d           = s_q;
        s_d.int_sync  = {s_q.int_sync[1:0], int_osc_pin};
        s_d.ext_sync  = {s_q.ext_sync[1:0], ext_osc_pin};
        s_d.xtal_sync = {s_q.xtal_sync[0], ext_osc_settled_pin};
        if (int_rise) begin
            s_d.int_half = ~s_q.int_half;
        end
        if (ext_rise) begin
            s_d.ext_half = ~s_q.ext_half;
        end
        s_d.crystal_valid = s_q.xtal_sync[1] &&
                            ext_osc_mode_field[2:1] == XMODE_CRYSTAL;

        // Register writes; unused bits are simply not stored.
        if (wr_sel) begin
            s_d.sysclk_source_select = sfr_req.wdata[SYSCLK_SEL_LSB +: 2];
        end
        if (wr_ctrl) begin
            s_d.mult_enable       = sfr_req.wdata[MULT_EN_BIT];
            s_d.mult_input_select = sfr_req.wdata[MULT_SEL_LSB +: 2];
            s_d.mult_initialize   = sfr_req.wdata[MULT_INIT_BIT];
        end

        // Multiplier sequence.
        case (s_q.mstate)
            CMS_M_OFF: begin
                if (s_d.mult_enable) begin
                    s_d.mstate = CMS_M_ENABLED;
                end
            end
            CMS_M_ENABLED: begin
                if (wr_ctrl && sfr_req.wdata[MULT_INIT_BIT]) begin
                    s_d.mstate   = CMS_M_LOCKING;
                    s_d.lock_cnt = '0;
                end
            end
            CMS_M_LOCKING: begin
                if (s_q.lock_cnt < 16'(MULT_LOCK_CYCLES)) begin
                    s_d.lock_cnt = s_q.lock_cnt + 16'h0001;
                end else if (s_q.period_valid) begin
                    s_d.mstate = CMS_M_LOCKED;
                end
            end
            CMS_M_LOCKED: begin
                if (wr_ctrl && sfr_req.wdata[MULT_INIT_BIT] && !s_q.mult_initialize) begin
                    s_d.mstate   = CMS_M_LOCKING;
                    s_d.lock_cnt = '0;
                end
            end
            default: s_d.mstate = CMS_M_OFF;
        endcase
        if (!s_d.mult_enable) begin
            s_d.mstate = CMS_M_OFF;
        end

        // Input period measurement and quarter-period output pulses.
        s_d.ticks.mult_tick = 1'b0;
        if (!s_q.mult_enable) begin
            s_d.per_cnt      = '0;
            s_d.period_valid = 1'b0;
            s_d.phase        = '0;
        end else if (mult_in_tick) begin
            s_d.per_cnt          = '0;
            s_d.period           = s_q.per_cnt + PER_W'(1);
            s_d.period_valid     = 1'b1;
            s_d.phase            = '0;
            s_d.ticks.mult_tick  = s_q.period_valid;
        end else begin
            if (s_q.per_cnt != '1) begin
                s_d.per_cnt = s_q.per_cnt + PER_W'(1);
            end
            if (s_q.period_valid) begin
                if (s_q.phase + PER_W'(1) >= quarter) begin
                    s_d.phase           = '0;
                    s_d.ticks.mult_tick = 1'b1;
                end else begin
                    s_d.phase = s_q.phase + PER_W'(1);
                end
            end
        end

        // Source change only on a pulse of the new source, so no pulse is cut short.
        new_tick = src_tick(s_q.sysclk_source_select, int_rise, ext_rise, s_q.ticks.mult_tick);
        if (s_q.sysclk_source_select != s_q.active_sel &&
            s_q.sysclk_source_select != CODE_RESERVED && new_tick) begin
            s_d.active_sel = s_q.sysclk_source_select;
        end
        s_d.ticks.sysclk_tick = src_tick(s_q.active_sel, int_rise, ext_rise,
                                         s_q.ticks.mult_tick);
        s_d.ticks.ext_periph_tick = ext_rise;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q                      <= '0;
            s_q.mult_enable          <= MULT_CTRL_RESET[MULT_EN_BIT];
            s_q.sysclk_source_select <= SYSCLK_SEL_RESET[SYSCLK_SEL_LSB +: 2];
            s_q.active_sel           <= CSEL_INT;
            s_q.mstate               <= CMS_M_OFF;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        case (sfr_req.addr)
            SYSCLK_SEL_ADDR: sfr_rdata = {6'h00, s_q.sysclk_source_select};
            MULT_CTRL_ADDR:  sfr_rdata = {s_q.mult_enable, s_q.mult_initialize,
                                          s_q.mstate == CMS_M_LOCKED, 3'h0,
                                          s_q.mult_input_select};
            default:         sfr_rdata = 8'h00;
        endcase
    end

    assign crystal_valid_flag = s_q.crystal_valid;
    assign ticks              = s_q.ticks;

    chk_rsvd_read_zero: assert property (@(posedge clk) disable iff (reset)
        sfr_req.addr == MULT_CTRL_ADDR |-> sfr_rdata[4:2] == 3'h0)
        else $error("Unused multiplier control bits read nonzero.");

    chk_locked_needs_en: assert property (@(posedge clk) disable iff (reset)
        sfr_rdata[MULT_LOCKED_BIT] && sfr_req.addr == MULT_CTRL_ADDR |-> s_q.mult_enable)
        else $error("Ready flag set while multiplier disabled.");

    chk_init_starts_lock: assert property (@(posedge clk) disable iff (reset)
        s_q.mstate == CMS_M_ENABLED && s_q.mult_enable && wr_ctrl &&
        sfr_req.wdata[MULT_EN_BIT] && sfr_req.wdata[MULT_INIT_BIT]
        |=> s_q.mstate == CMS_M_LOCKING)
        else $error("Initialize write did not start locking.");

    chk_lock_not_early: assert property (@(posedge clk) disable iff (reset)
        $rose(s_q.mstate == CMS_M_LOCKED) |-> $past(s_q.lock_cnt) >= 16'(MULT_LOCK_CYCLES))
        else $error("Ready flag rose before the lock time.");

    chk_disable_clears: assert property (@(posedge clk) disable iff (reset)
        wr_ctrl && !sfr_req.wdata[MULT_EN_BIT] |=> s_q.mstate == CMS_M_OFF ##1
        !s_q.ticks.mult_tick)
        else $error("Disable write did not stop the multiplier.");

    chk_crystal_mode: assert property (@(posedge clk) disable iff (reset)
        crystal_valid_flag |-> $past(ext_osc_mode_field[2:1]) == XMODE_CRYSTAL)
        else $error("Crystal valid outside crystal mode.");

    chk_sysclk_int: assert property (@(posedge clk) disable iff (reset)
        s_q.active_sel == CSEL_INT && int_rise |=> ticks.sysclk_tick)
        else $error("Internal oscillator edge not passed to system clock.");

    chk_periph_ext: assert property (@(posedge clk) disable iff (reset)
        ext_rise |=> ticks.ext_periph_tick)
        else $error("External oscillator edge not passed to peripherals.");

    chk_switch_clean: assert property (@(posedge clk) disable iff (reset)
        s_q.active_sel != $past(s_q.active_sel) |->
        $past(src_tick(s_q.sysclk_source_select, int_rise, ext_rise, s_q.ticks.mult_tick)))
        else $error("Source switched off a pulse boundary.");

    chk_reserved_sel: assert property (@(posedge clk) disable iff (reset)
        s_q.active_sel != CODE_RESERVED)
        else $error("Reserved source code became active.");

endmodule : cms_clock_control

// ==== cms_pkg.sv ====
/*
 * Shared constants and types for the clock multiplier and system clock select block.
 * Assumes a single 10 MHz control clock and an 8-bit special function register port.
 */
package cms_pkg;

    localparam int unsigned CLK_HZ              = 10_000_000;
    localparam logic [7:0]  SYSCLK_SEL_ADDR     = 8'hA9;
    localparam logic [7:0]  MULT_CTRL_ADDR      = 8'hBE;
    localparam logic [7:0]  SYSCLK_SEL_RESET    = 8'h00;
    localparam logic [7:0]  MULT_CTRL_RESET     = 8'h00;
    localparam int unsigned MULT_EN_BIT         = 7;
    localparam int unsigned MULT_INIT_BIT       = 6;
    localparam int unsigned MULT_LOCKED_BIT     = 5;
    localparam int unsigned MULT_SEL_LSB        = 0;
    localparam int unsigned SYSCLK_SEL_LSB      = 0;
    localparam int unsigned MULT_FACTOR         = 4;
    localparam int unsigned MULT_LOCK_TIME_NS   = 5_000;
    localparam int unsigned MULT_LOCK_CYCLES    =
        (MULT_LOCK_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    localparam logic [1:0]  MSEL_INT_DIV2       = 2'h0;
    localparam logic [1:0]  MSEL_EXT            = 2'h1;
    localparam logic [1:0]  MSEL_EXT_DIV2       = 2'h2;
    localparam logic [1:0]  CSEL_INT            = 2'h0;
    localparam logic [1:0]  CSEL_EXT            = 2'h1;
    localparam logic [1:0]  CSEL_MULT           = 2'h2;
    localparam logic [1:0]  CODE_RESERVED       = 2'h3;
    localparam logic [1:0]  XMODE_CRYSTAL       = 2'h3;

    typedef enum logic [3:0] {
        CMS_M_OFF     = 4'h1,
        CMS_M_ENABLED = 4'h2,
        CMS_M_LOCKING = 4'h4,
        CMS_M_LOCKED  = 4'h8
    } cms_mstate_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } cms_sfr_req_t;

    typedef struct packed {
        logic sysclk_tick;
        logic mult_tick;
        logic ext_periph_tick;
    } cms_ticks_t;

endpackage : cms_pkg
